// [logic/fsls_top.v]
// start-up handshake, first address capture and lock register access
`timescale 1ns/1ns
`default_nettype none
`include "fsls_consts.vh"
module fsls_top (
   input  wire                    i_clk,
   input  wire                    i_nrst,
   input  wire                    i_core_por_ok,
   input  wire                    i_io_por_ok,
   input  wire                    i_core_pd_low,
   input  wire                    i_reset_pulse_n,
   input  wire                    i_write_prot,
   input  wire                    i_addr_latch,
   input  wire                    i_out_en_n,
   input  wire                    i_burst_clk,
   input  wire [`FSLS_ADDR_W-1:0] i_addr,
   input  wire                    i_pe_req,
   input  wire [7:0]              i_pe_blk,
   output wire                    o_pe_grant,
   output wire                    o_pe_refuse,
   output reg                     o_handshake,
   output reg                     o_addr_valid,
   output reg  [`FSLS_ADDR_W-1:0] o_start_addr,
   output reg                     o_cfg_bit_four,
   input  wire [7:0]              i_axi_awaddr,
   input  wire                    i_axi_awvalid,
   output wire                    o_axi_awready,
   input  wire [31:0]             i_axi_wdata,
   input  wire [3:0]              i_axi_wstrb,
   input  wire                    i_axi_wvalid,
   output wire                    o_axi_wready,
   output reg  [1:0]              o_axi_bresp,
   output reg                     o_axi_bvalid,
   input  wire                    i_axi_bready,
   input  wire [7:0]              i_axi_araddr,
   input  wire                    i_axi_arvalid,
   output wire                    o_axi_arready,
   output reg  [31:0]             o_axi_rdata,
   output reg  [1:0]              o_axi_rresp,
   output reg                     o_axi_rvalid,
   input  wire                    i_axi_rready
);

   localparam [2:0]  ST_HOLD    = 3'h0;
   localparam [2:0]  ST_DELAY   = 3'h1;
   localparam [2:0]  ST_WAIT_OE = 3'h2;
   localparam [2:0]  ST_SEQ     = 3'h3;
   localparam [2:0]  ST_READY   = 3'h4;
   localparam [15:0] DLY_RST    = `FSLS_RLS_DELAY_CYC;
   localparam        SW         = `FSLS_ADDR_W + 8;

   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   // every pin and supply indication except the program/erase request and block goes through two flops
   wire [SW-1:0] pins = {i_core_por_ok, i_io_por_ok, i_core_pd_low,
                         i_reset_pulse_n, i_write_prot, i_addr_latch,
                         i_out_en_n, i_burst_clk, i_addr};
   reg  [SW-1:0] sync1_q;
   reg  [SW-1:0] sync2_q;
   reg           kclk_q;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_q <= {SW{1'b0}};
         sync2_q <= {SW{1'b0}};
         kclk_q  <= 1'b0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         kclk_q  <= sync2_q[`FSLS_ADDR_W];
      end
   end

   wire                    core_ok_s = sync2_q[SW-1];
   wire                    io_ok_s   = sync2_q[SW-2];
   wire                    pd_low_s  = sync2_q[SW-3];
   wire                    rp_n_s    = sync2_q[SW-4];
   wire                    wp_s      = sync2_q[SW-5];
   wire                    latch_s   = sync2_q[SW-6];
   wire                    oe_n_s    = sync2_q[SW-7];
   wire                    kclk_s    = sync2_q[`FSLS_ADDR_W];
   wire [`FSLS_ADDR_W-1:0] addr_s    = sync2_q[`FSLS_ADDR_W-1:0];
   wire                    k_rise    = kclk_s && !kclk_q;

   // power loss and reset pulse both hold the start-up logic
   wire pwr_fault = !core_ok_s || !io_ok_s || pd_low_s;
   wire rst_cond  = pwr_fault || !rp_n_s;

   reg [2:0]  st_q;
   reg [15:0] dly_cnt_q;
   reg [15:0] dly_cfg_q;
   reg [1:0]  edge_cnt_q;
   reg        por_pend_q;

   // a zero delay setting still gives one cycle
   wire [15:0] dly_last = (dly_cfg_q == 16'h0000) ? 16'h0000 :
                          dly_cfg_q - 16'h0001;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q         <= ST_HOLD;
         dly_cnt_q    <= 16'h0000;
         edge_cnt_q   <= 2'h0;
         por_pend_q   <= 1'b1;
         o_handshake  <= 1'b0;
         o_addr_valid <= 1'b0;
         o_start_addr <= {`FSLS_ADDR_W{1'b0}};
      end else if (rst_cond) begin
         st_q         <= ST_HOLD;
         dly_cnt_q    <= 16'h0000;
         edge_cnt_q   <= 2'h0;
         o_handshake  <= 1'b0;
         o_addr_valid <= 1'b0;
         if (pwr_fault) begin
            por_pend_q <= 1'b1;
         end
      end else begin
         case (st_q)
            ST_HOLD: begin
               dly_cnt_q <= 16'h0000;
               st_q      <= ST_DELAY;
            end
            ST_DELAY: begin
               dly_cnt_q <= dly_cnt_q + 16'h0001;
               if (dly_cnt_q >= dly_last) begin
                  o_handshake <= 1'b1;
                  edge_cnt_q  <= 2'h0;
                  if (por_pend_q && oe_n_s) begin
                     st_q <= ST_WAIT_OE;
                  end else begin
                     st_q <= ST_SEQ;
                  end
               end
            end
            ST_WAIT_OE: begin
               if (!oe_n_s) begin
                  st_q <= ST_SEQ;
               end
            end
            ST_SEQ: begin
               por_pend_q <= 1'b0;
               // host clock edges only count while it keeps start conditions
               if (k_rise && latch_s && !oe_n_s) begin
                  edge_cnt_q <= edge_cnt_q + 2'h1;
                  if (edge_cnt_q == `FSLS_CAPTURE_EDGE) begin
                     o_start_addr <= addr_s;
                  end
                  if (edge_cnt_q == `FSLS_LAST_EDGE) begin
                     o_addr_valid <= 1'b1;
                     st_q         <= ST_READY;
                  end
               end
            end
            ST_READY: begin
               st_q <= ST_READY;
            end
            default: begin
               st_q <= ST_HOLD;
            end
         endcase
      end
   end

   // register bus: write side
   reg        aw_held_q;
   reg [7:0]  aw_addr_q;
   reg        w_held_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   reg [7:0]  lock_sel_q;
   reg        lock_cmd_q;
   reg [1:0]  lock_op_q;

   assign o_axi_awready = !aw_held_q && !o_axi_bvalid;
   assign o_axi_wready  = !w_held_q && !o_axi_bvalid;
   assign o_axi_arready = !o_axi_rvalid;

   wire do_wr = aw_held_q && w_held_q;
   wire [31:0] cur_ctrl = {16'h0000, dly_cfg_q};
   wire [31:0] cur_sel  = {24'h000000, lock_sel_q};
   wire [31:0] new_ctrl = merge(cur_ctrl, w_data_q, w_strb_q);
   wire [31:0] new_sel  = merge(cur_sel, w_data_q, w_strb_q);
   wire wr_ctrl = do_wr && (aw_addr_q == `FSLS_OFF_CTRL);
   wire wr_cfg  = do_wr && (aw_addr_q == `FSLS_OFF_CFG) && w_strb_q[0];
   wire wr_sel  = do_wr && (aw_addr_q == `FSLS_OFF_LOCK_SEL);
   wire wr_cmd  = do_wr && (aw_addr_q == `FSLS_OFF_LOCK_CMD) && w_strb_q[0];
   wire wr_map  = (aw_addr_q == `FSLS_OFF_CTRL) ||
                  (aw_addr_q == `FSLS_OFF_CFG) ||
                  (aw_addr_q == `FSLS_OFF_LOCK_SEL) ||
                  (aw_addr_q == `FSLS_OFF_LOCK_CMD);

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_held_q      <= 1'b0;
         aw_addr_q      <= 8'h00;
         w_held_q       <= 1'b0;
         w_data_q       <= 32'h00000000;
         w_strb_q       <= 4'h0;
         o_axi_bvalid   <= 1'b0;
         o_axi_bresp    <= `FSLS_RESP_OKAY;
         dly_cfg_q      <= DLY_RST;
         lock_sel_q     <= `FSLS_LOCK_SEL_RST;
         lock_cmd_q     <= 1'b0;
         lock_op_q      <= 2'h0;
         o_cfg_bit_four <= `FSLS_CFG_BIT4_RST;
      end else begin
         lock_cmd_q <= wr_cmd;
         if (i_axi_awvalid && o_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= {i_axi_awaddr[7:2], 2'h0};
         end
         if (i_axi_wvalid && o_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= i_axi_wdata;
            w_strb_q <= i_axi_wstrb;
         end
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            o_axi_bvalid <= 1'b1;
            o_axi_bresp  <= wr_map ? `FSLS_RESP_OKAY : `FSLS_RESP_SLVERR;
         end else if (o_axi_bvalid && i_axi_bready) begin
            o_axi_bvalid <= 1'b0;
         end
         if (wr_ctrl) begin
            dly_cfg_q <= new_ctrl[15:0];
         end
         if (wr_sel) begin
            lock_sel_q <= new_sel[7:0];
         end
         if (wr_cmd) begin
            lock_op_q <= w_data_q[1:0];
         end
         // hardware setting wins over a software write in the same cycle
         if (!o_handshake) begin
            o_cfg_bit_four <= 1'b1;
         end else if (wr_cfg) begin
            o_cfg_bit_four <= w_data_q[`FSLS_CFG_BIT4_POS];
         end
      end
   end

   // register bus: read side
   wire [2:0] sel_state;
   reg [31:0] rd_data;
   reg        rd_ok;

   always @* begin
      rd_data = 32'h00000000;
      rd_ok   = 1'b1;
      case ({i_axi_araddr[7:2], 2'h0})
         `FSLS_OFF_CTRL: begin
            rd_data[15:0] = dly_cfg_q;
         end
         `FSLS_OFF_CFG: begin
            rd_data[`FSLS_CFG_BIT4_POS] = o_cfg_bit_four;
         end
         `FSLS_OFF_STATUS: begin
            rd_data[`FSLS_ST_HS_POS]    = o_handshake;
            rd_data[`FSLS_ST_VALID_POS] = o_addr_valid;
            rd_data[`FSLS_ST_POR_POS]   = por_pend_q;
            rd_data[`FSLS_ST_FSM_LSB +: 3] = st_q;
         end
         `FSLS_OFF_START_ADDR: begin
            rd_data[`FSLS_ADDR_W-1:0] = o_start_addr;
         end
         `FSLS_OFF_LOCK_SEL: begin
            rd_data[7:0] = lock_sel_q;
         end
         `FSLS_OFF_LOCK_CMD: begin
            rd_data = 32'h00000000;
         end
         `FSLS_OFF_LOCK_STATE: begin
            rd_data[2:0] = sel_state;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_axi_rvalid <= 1'b0;
         o_axi_rdata  <= 32'h00000000;
         o_axi_rresp  <= `FSLS_RESP_OKAY;
      end else if (i_axi_arvalid && o_axi_arready) begin
         o_axi_rvalid <= 1'b1;
         o_axi_rdata  <= rd_data;
         o_axi_rresp  <= rd_ok ? `FSLS_RESP_OKAY : `FSLS_RESP_SLVERR;
      end else if (o_axi_rvalid && i_axi_rready) begin
         o_axi_rvalid <= 1'b0;
      end
   end

   fsls_lock u_lock (
      .i_clk       (i_clk),
      .i_nrst      (i_nrst),
      .i_clr       (rst_cond),
      .i_wp        (wp_s),
      .i_cmd_valid (lock_cmd_q),
      .i_cmd_op    (lock_op_q),
      .i_cmd_blk   (lock_sel_q),
      .i_sel_blk   (lock_sel_q),
      .i_pe_req    (i_pe_req),
      .i_pe_blk    (i_pe_blk),
      .o_sel_state (sel_state),
      .o_pe_grant  (o_pe_grant),
      .o_pe_refuse (o_pe_refuse)
   );

endmodule
`default_nettype wire

// [shared/fsls_consts.vh]
// constants for the flash start-up and block lock logic
`ifndef FSLS_CONSTS_VH
`define FSLS_CONSTS_VH

// clock and timing
`define FSLS_CLK_NS          4
`define FSLS_RLS_DELAY_NS    1000
`define FSLS_RLS_DELAY_CYC   ((`FSLS_RLS_DELAY_NS + `FSLS_CLK_NS - 1) / `FSLS_CLK_NS)
`define FSLS_CAPTURE_EDGE    2'h2
`define FSLS_LAST_EDGE       2'h3

// array geometry
`define FSLS_NBLK            131
`define FSLS_ADDR_W          23

// register byte offsets
`define FSLS_OFF_CTRL        8'h00
`define FSLS_OFF_CFG         8'h04
`define FSLS_OFF_STATUS      8'h08
`define FSLS_OFF_START_ADDR  8'h0C
`define FSLS_OFF_LOCK_SEL    8'h10
`define FSLS_OFF_LOCK_CMD    8'h14
`define FSLS_OFF_LOCK_STATE  8'h18

// field positions
`define FSLS_CFG_BIT4_POS    4
`define FSLS_ST_HS_POS       0
`define FSLS_ST_VALID_POS    1
`define FSLS_ST_POR_POS      2
`define FSLS_ST_FSM_LSB      4

// reset values
`define FSLS_CFG_BIT4_RST    1'b1
`define FSLS_LOCK_SEL_RST    8'h00

// lock commands
`define FSLS_OP_LOCK         2'h1
`define FSLS_OP_UNLOCK       2'h2
`define FSLS_OP_LOCKDOWN     2'h3

// bus answers
`define FSLS_RESP_OKAY       2'h0
`define FSLS_RESP_SLVERR     2'h2

`endif

// [logic/fsls_lock.v]
// per-block lock, lock-down and write-protect state for all blocks
`timescale 1ns/1ns
`default_nettype none
module fsls_lock (
   input  wire       i_clk,
   input  wire       i_nrst,
   input  wire       i_clr,
   input  wire       i_wp,
   input  wire       i_cmd_valid,
   input  wire [1:0] i_cmd_op,
   input  wire [7:0] i_cmd_blk,
   input  wire [7:0] i_sel_blk,
   input  wire       i_pe_req,
   input  wire [7:0] i_pe_blk,
   output reg  [2:0] o_sel_state,
   output reg        o_pe_grant,
   output reg        o_pe_refuse
);
`include "fsls_consts.vh"

   localparam [7:0] NBLK = `FSLS_NBLK;

   reg [`FSLS_NBLK-1:0] locked_q;
   reg [`FSLS_NBLK-1:0] lockdown_q;
   reg [`FSLS_NBLK-1:0] saved_q;
   reg                  wp_q;
   integer              i;

   function blk_ok;
      input [7:0] b;
      begin
         blk_ok = (b < NBLK);
      end
   endfunction

   // program/erase only with lock clear and no enforced lock-down
   wire pe_in   = blk_ok(i_pe_blk);
   wire pe_ok   = pe_in && !locked_q[i_pe_blk] &&
                  !(lockdown_q[i_pe_blk] && !i_wp);
   wire cmd_in  = blk_ok(i_cmd_blk);
   wire cmd_frz = cmd_in && lockdown_q[i_cmd_blk] && !i_wp;
   wire sel_in  = blk_ok(i_sel_blk);

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         locked_q    <= {`FSLS_NBLK{1'b1}};
         lockdown_q  <= {`FSLS_NBLK{1'b0}};
         saved_q     <= {`FSLS_NBLK{1'b1}};
         wp_q        <= 1'b0;
         o_sel_state <= 3'h0;
         o_pe_grant  <= 1'b0;
         o_pe_refuse <= 1'b0;
      end else begin
         wp_q        <= i_wp;
         o_pe_grant  <= i_pe_req && pe_ok;
         o_pe_refuse <= i_pe_req && !pe_ok;
         o_sel_state <= sel_in ? {i_wp, lockdown_q[i_sel_blk],
                                  locked_q[i_sel_blk]} : 3'h0;
         if (i_clr) begin
            // hardware reset or power loss: everything back to locked
            locked_q   <= {`FSLS_NBLK{1'b1}};
            lockdown_q <= {`FSLS_NBLK{1'b0}};
            saved_q    <= {`FSLS_NBLK{1'b1}};
         end else begin
            for (i = 0; i < `FSLS_NBLK; i = i + 1) begin
               if (lockdown_q[i] && wp_q && !i_wp) begin
                  saved_q[i]  <= locked_q[i];
                  locked_q[i] <= 1'b1;
               end
               if (lockdown_q[i] && !wp_q && i_wp) begin
                  locked_q[i] <= saved_q[i];
               end
            end
            // a command in the same cycle as a rising pin edge wins; on a falling edge a locked-down block ignores it
            if (i_cmd_valid && cmd_in && !cmd_frz) begin
               case (i_cmd_op)
                  `FSLS_OP_LOCK: begin
                     locked_q[i_cmd_blk] <= 1'b1;
                  end
                  `FSLS_OP_UNLOCK: begin
                     locked_q[i_cmd_blk] <= 1'b0;
                  end
                  `FSLS_OP_LOCKDOWN: begin
                     lockdown_q[i_cmd_blk] <= 1'b1;
                     locked_q[i_cmd_blk]   <= 1'b1;
                     if (!i_wp) begin
                        saved_q[i_cmd_blk] <= locked_q[i_cmd_blk];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

endmodule
`default_nettype wire

// [sim/fsls_assertions.sv]
// concurrent checks on the start-up handshake and program/erase answers
`timescale 1ns/1ns
`default_nettype none
`include "fsls_consts.vh"
module fsls_assertions (
   input wire logic                    i_clk,
   input wire logic                    i_nrst,
   input wire logic                    i_core_por_ok,
   input wire logic                    i_io_por_ok,
   input wire logic                    i_core_pd_low,
   input wire logic                    i_reset_pulse_n,
   input wire logic                    i_pe_req,
   input wire logic [7:0]              i_pe_blk,
   input wire logic                    o_pe_grant,
   input wire logic                    o_pe_refuse,
   input wire logic                    o_handshake,
   input wire logic                    o_addr_valid,
   input wire logic [`FSLS_ADDR_W-1:0] o_start_addr,
   input wire logic                    o_cfg_bit_four
);
   wire pins_good = i_core_por_ok && i_io_por_ok && i_reset_pulse_n
                    && !i_core_pd_low;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // four cycles cover the two-stage pin synchronisers
   sequence s_pin_reset; (!i_reset_pulse_n) [*4]; endsequence
   sequence s_no_power; (!i_core_por_ok || !i_io_por_ok) [*4]; endsequence
   sequence s_far_blk; i_pe_req && i_pe_blk >= `FSLS_NBLK; endsequence
   chk_pin_holds: assert property (s_pin_reset |-> !o_handshake)
      else $error("handshake high in reset pulse");
   chk_por_holds: assert property (s_no_power |-> !o_handshake)
      else $error("handshake high without supplies");
   chk_brown_holds: assert property (i_core_pd_low [*4] |-> !o_handshake)
      else $error("handshake high in brownout");
   chk_release_late: assert property ($rose(o_handshake) |-> $past(pins_good, 3))
      else $error("handshake released too early");
   chk_abort_cfg: assert property ($fell(o_handshake) |-> ##[0:2] o_cfg_bit_four)
      else $error("config bit four not set on abort");
   chk_abort_valid: assert property ((!o_handshake) [*2] |-> !o_addr_valid)
      else $error("capture not aborted");
   chk_valid_hs: assert property ($rose(o_addr_valid) |-> o_handshake)
      else $error("capture done while held");
   chk_start_steady: assert property (o_addr_valid && $past(o_addr_valid) |-> $stable(o_start_addr))
      else $error("start address moved");
   chk_pe_answer: assert property (i_pe_req |=> o_pe_grant != o_pe_refuse)
      else $error("program request not answered once");
   chk_pe_quiet: assert property (!i_pe_req |=> !o_pe_grant && !o_pe_refuse)
      else $error("answer without request");
   chk_far_refused: assert property (s_far_blk |=> o_pe_refuse)
      else $error("missing block not refused");
   cover property ($rose(o_addr_valid));
endmodule
`default_nettype wire

// [sim/fsls_host_model.sv]
// host model: drives the burst clock and start address after release
`timescale 1ns/1ns
`default_nettype none
`include "fsls_consts.vh"
module fsls_host_model #(
   parameter int STILL = 150
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_handshake,
   input  wire logic                    i_oe_late,
   input  wire logic [`FSLS_ADDR_W-1:0] i_addr_val,
   output var  logic                    o_burst_clk,
   output var  logic                    o_addr_latch,
   output var  logic                    o_out_en_n,
   output var  logic [`FSLS_ADDR_W-1:0] o_addr,
   output var  logic                    o_done
);
   initial begin
      o_burst_clk = 0;
      o_addr_latch = 1;
      o_out_en_n = 1;
      o_addr = '0;
      o_done = 0;
      forever begin
         @(posedge i_clk);
         // a released bus keeps changing so a late capture cannot pass
         // address stands from before release past the capture edge
         o_addr <= o_done ? ~o_addr : i_addr_val;
         o_out_en_n <= i_oe_late;
         if (!i_handshake)
            o_done <= 0;
         else if (!o_done) begin
            if (i_oe_late) begin
               repeat (20) @(posedge i_clk);
               o_out_en_n <= 0;
            end
            repeat (STILL) @(posedge i_clk);
            for (int k = 1; k <= 4; k++) begin
               o_burst_clk <= 1;
               repeat (4) @(posedge i_clk);
               if (k == 3)
                  o_addr <= ~o_addr;
               o_burst_clk <= 0;
               repeat (4) @(posedge i_clk);
            end
            o_done <= 1;
         end
      end
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for start-up, address capture and block locks
`timescale 1ns/1ns
`default_nettype none
`include "fsls_consts.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   fails++; $display("[ERR] %s exp %0h got %0h", nm, (e), (g)); end end
module testbench;
   localparam int DLY = 8;
   logic                    i_clk = 0, i_nrst = 0, oe_late = 1;
   logic                    i_core_por_ok = 0, i_io_por_ok = 0;
   logic                    i_core_pd_low = 0, i_reset_pulse_n = 1;
   logic                    i_write_prot = 1, i_pe_req = 0;
   logic [7:0]              i_pe_blk = 0, i_axi_awaddr = 0, i_axi_araddr = 0;
   logic [7:0]              blk;
   logic [31:0]             i_axi_wdata = 0, d;
   logic [3:0]              i_axi_wstrb = 4'hF;
   logic [1:0]              r;
   logic                    i_axi_awvalid = 0, i_axi_wvalid = 0;
   logic                    i_axi_bready = 0, i_axi_arvalid = 0, i_axi_rready = 0;
   logic [`FSLS_ADDR_W-1:0] addr_val = 0;
   wire  [`FSLS_ADDR_W-1:0] i_addr, o_start_addr;
   wire                     i_burst_clk, i_addr_latch, i_out_en_n, done;
   wire                     o_pe_grant, o_pe_refuse, o_handshake, o_cfg_bit_four;
   wire                     o_addr_valid, o_axi_awready, o_axi_wready;
   wire                     o_axi_bvalid, o_axi_arready, o_axi_rvalid;
   wire  [1:0]              o_axi_bresp, o_axi_rresp;
   wire  [31:0]             o_axi_rdata;
   int                      fails = 0, num_checks = 0, cyc = 0, n;
   int                      m_wp, m_ld, m_lk, m_sv;
   int                      pre[6] = '{2, 3, 2, 0, 2, 0};
   always #2 i_clk = ~i_clk;
   fsls_top fsls_top_inst (.i_clk, .i_nrst, .i_core_por_ok, .i_io_por_ok,
      .i_core_pd_low, .i_reset_pulse_n, .i_write_prot, .i_addr_latch,
      .i_out_en_n, .i_burst_clk, .i_addr, .i_pe_req, .i_pe_blk, .o_pe_grant,
      .o_pe_refuse, .o_handshake, .o_addr_valid, .o_start_addr,
      .o_cfg_bit_four, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready,
      .i_axi_wdata, .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp,
      .o_axi_bvalid, .i_axi_bready, .i_axi_araddr, .i_axi_arvalid,
      .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid,
      .i_axi_rready);
   fsls_host_model #(.STILL(150)) fsls_host_model_inst (.i_clk,
      .i_handshake(o_handshake), .i_oe_late(oe_late), .i_addr_val(addr_val),
      .o_burst_clk(i_burst_clk), .o_addr_latch(i_addr_latch),
      .o_out_en_n(i_out_en_n), .o_addr(i_addr), .o_done(done));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         fails++;
         end_sim;
      end
   end
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_axi_awaddr <= a;
      i_axi_wdata <= v;
      i_axi_awvalid <= 1;
      i_axi_wvalid <= 1;
      i_axi_bready <= 1;
      do begin
         @(posedge i_clk);
         if (i_axi_awvalid && o_axi_awready)
            i_axi_awvalid <= 0;
         if (i_axi_wvalid && o_axi_wready)
            i_axi_wvalid <= 0;
      end while (!o_axi_bvalid);
      i_axi_bready <= 0;
      r = o_axi_bresp;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge i_clk);
      i_axi_araddr <= a;
      i_axi_arvalid <= 1;
      i_axi_rready <= 1;
      do begin
         @(posedge i_clk);
         if (i_axi_arvalid && o_axi_arready)
            i_axi_arvalid <= 0;
      end while (!o_axi_rvalid);
      i_axi_rready <= 0;
      d = o_axi_rdata;
      r = o_axi_rresp;
   endtask
   task automatic pe_try(input logic [7:0] b, input logic g);
      @(posedge i_clk);
      i_pe_req <= 1;
      i_pe_blk <= b;
      @(posedge i_clk);
      i_pe_req <= 0;
      #1;
      `CHK("grant", g, o_pe_grant)
      `CHK("refuse", !g, o_pe_refuse)
   endtask
   task automatic wait_seq;
      n = 0;
      while (!o_addr_valid && n < 2000) begin
         @(posedge i_clk);
         n++;
      end
      `CHK("valid", 1'b1, o_addr_valid)
      `CHK("start", addr_val, o_start_addr)
   endtask
   // wp edges and commands are kept apart so neither overrides the other
   task automatic lock_step(input int op);
      if (op == 0) begin
         @(posedge i_clk);
         i_write_prot <= !m_wp[0];
         m_wp = !m_wp;
         if (m_ld && !m_wp) begin
            m_sv = m_lk;
            m_lk = 1;
         end else if (m_ld)
            m_lk = m_sv;
         repeat (6) @(posedge i_clk);
      end else begin
         axi_wr(`FSLS_OFF_LOCK_CMD, op);
         if (!(m_ld && !m_wp)) begin
            if (op == 3)
               m_ld = 1;
            if (op == 3)
               m_sv = m_lk;
            m_lk = (op != 2);
         end
         repeat (3) @(posedge i_clk);
      end
      axi_rd(`FSLS_OFF_LOCK_STATE);
      `CHK("lock", {m_wp[0], m_ld[0], m_lk[0]}, d[2:0])
      pe_try(blk, !m_lk[0]);
   endtask
   initial begin
      void'($urandom(32'h2a4e21b4));
      repeat (2) @(posedge i_clk);
      i_nrst <= 1;
      `CHK("cfg4_rst", 1'b1, o_cfg_bit_four)
      axi_rd(`FSLS_OFF_CTRL);
      `CHK("ctrl_rst", `FSLS_RLS_DELAY_CYC, d[15:0])
      axi_rd(8'h40);
      `CHK("unmapped", `FSLS_RESP_SLVERR, r)
      axi_wr(`FSLS_OFF_CTRL, DLY);
      `CHK("bresp", `FSLS_RESP_OKAY, r)
      `CHK("hs_por", 1'b0, o_handshake)
      $display("test reset done");
      addr_val <= `FSLS_ADDR_W'($urandom);
      i_core_por_ok <= 1;
      i_io_por_ok <= 1;
      n = 0;
      while (!o_handshake && n < 1000) begin
         @(posedge i_clk);
         n++;
      end
      `CHK("release", 1'b1, n > DLY && n < DLY + 8)
      wait_seq;
      axi_rd(`FSLS_OFF_START_ADDR);
      `CHK("start_reg", addr_val, d[`FSLS_ADDR_W-1:0])
      $display("test power-on done");
      axi_wr(`FSLS_OFF_CFG, 0);
      `CHK("cfg4_clr", 1'b0, o_cfg_bit_four)
      oe_late <= 0;
      addr_val <= `FSLS_ADDR_W'($urandom);
      i_reset_pulse_n <= 0;
      repeat (6) @(posedge i_clk);
      `CHK("hs_pin", 1'b0, o_handshake)
      `CHK("valid_pin", 1'b0, o_addr_valid)
      `CHK("cfg4_pin", 1'b1, o_cfg_bit_four)
      i_reset_pulse_n <= 1;
      wait_seq;
      $display("test reset pin done");
      addr_val <= `FSLS_ADDR_W'($urandom);
      i_core_pd_low <= 1;
      repeat (6) @(posedge i_clk);
      `CHK("hs_brown", 1'b0, o_handshake)
      i_core_pd_low <= 0;
      wait_seq;
      $display("test brownout done");
      i_io_por_ok <= 0;
      repeat (6) @(posedge i_clk);
      `CHK("hs_io", 1'b0, o_handshake)
      i_io_por_ok <= 1;
      i_reset_pulse_n <= 0;
      repeat (6) @(posedge i_clk);
      i_reset_pulse_n <= 1;
      wait_seq;
      $display("test io supply done");
      blk = 8'($urandom % `FSLS_NBLK);
      axi_wr(`FSLS_OFF_LOCK_SEL, blk);
      repeat (2) @(posedge i_clk);
      axi_rd(`FSLS_OFF_LOCK_STATE);
      `CHK("lock_init", 3'b101, d[2:0])
      m_wp = 1;
      m_ld = 0;
      m_lk = 1;
      for (int k = 0; k < 32; k++)
         lock_step(k < 6 ? pre[k] : int'($urandom % 4));
      pe_try(8'(`FSLS_NBLK + $urandom % 125), 1'b0);
      $display("test locks done");
      end_sim;
   end
endmodule
bind fsls_top fsls_assertions fsls_assertions_inst (.i_clk, .i_nrst,
   .i_core_por_ok, .i_io_por_ok, .i_core_pd_low, .i_reset_pulse_n, .i_pe_req,
   .i_pe_blk, .o_pe_grant, .o_pe_refuse, .o_handshake, .o_addr_valid,
   .o_start_addr, .o_cfg_bit_four);
`default_nettype wire
